/* File: design/qs_pkg.sv */
// Package for the quick stop reaction selector: register map, field codes and states.
// Assumes a 32-bit APB register bus with one aligned word per register.
package qs_pkg;
   // Register byte offsets.
   localparam logic [7:0] OFS_OPTION = 8'h00;
   localparam logic [7:0] OFS_MODE = 8'h04;
   localparam logic [7:0] OFS_QS_DECEL = 8'h08;
   localparam logic [7:0] OFS_PROF_DECEL = 8'h0c;
   localparam logic [7:0] OFS_HOME_ACC = 8'h10;
   localparam logic [7:0] OFS_TABLE_DECEL = 8'h14;
   localparam logic [7:0] OFS_COMMAND = 8'h18;
   localparam logic [7:0] OFS_STATUS = 8'h1c;
   // Command register bit positions (write one to act; read as zero).
   localparam int CMD_QSTOP_BIT = 0;
   localparam int CMD_ENABLE_BIT = 1;
   // Status register bit positions.
   localparam int ST_STATE_LSB = 0;
   localparam int ST_SERVO_BIT = 4;
   localparam int ST_READY_BIT = 5;
   localparam int ST_BRAKE_BIT = 6;
   localparam int ST_DECEL_BIT = 7;
   localparam int ST_SRC_LSB = 8;
   localparam int ST_REFUSED_BIT = 12;
   // Quick stop option codes.
   localparam logic [3:0] OPT_BRAKE = 4'h0;
   localparam logic [3:0] OPT_CTRL_OFF = 4'h1;
   localparam logic [3:0] OPT_QS_OFF = 4'h2;
   localparam logic [3:0] OPT_CTRL_HOLD = 4'h5;
   localparam logic [3:0] OPT_QS_HOLD = 4'h6;
   // Reset values.
   localparam logic [3:0] OPTION_RST = OPT_QS_OFF;
   localparam logic [31:0] RATE_RST = 32'h0000_0000;
   // Control modes, as coded in the mode register.
   localparam logic [3:0] MODE_CSP = 4'h0;
   localparam logic [3:0] MODE_CSV = 4'h1;
   localparam logic [3:0] MODE_CST = 4'h2;
   localparam logic [3:0] MODE_PROFILE_POSITION = 4'h3;
   localparam logic [3:0] MODE_PROFILE_VELOCITY = 4'h4;
   localparam logic [3:0] MODE_PROFILE_TORQUE = 4'h5;
   localparam logic [3:0] MODE_CONTINUOUS_TO_TORQUE = 4'h6;
   localparam logic [3:0] MODE_JOG = 4'h7;
   localparam logic [3:0] MODE_HOMING = 4'h8;
   localparam logic [3:0] MODE_POINT_TABLE = 4'h9;
   localparam logic [3:0] MODE_RST = MODE_CSP;
   // Deceleration rate sources, as shown on decel_src.
   localparam logic [2:0] SRC_NONE = 3'h0;
   localparam logic [2:0] SRC_QUICK_STOP = 3'h1;
   localparam logic [2:0] SRC_PROFILE = 3'h2;
   localparam logic [2:0] SRC_HOMING = 3'h3;
   localparam logic [2:0] SRC_POINT_TABLE = 3'h4;
   // Drive states; the status code is the enum position.
   typedef enum logic [1:0] {
      ST_SWITCH_ON_DISABLED,
      ST_OPERATION_ENABLED,
      ST_DECELERATING,
      ST_QUICK_STOP_ACTIVE
   } drive_state_t;
endpackage

/* File: design/quick_stop_reaction_selector.sv */
// Quick stop reaction selector: picks brake or deceleration, the rate source and the end state.
// Assumes an APB master on pclk and motion logic on pclk that reports motor standstill.
// Assumes the motion logic holds motor_at_rest high only while the motor stands still.
`timescale 1ns/10ps
module quick_stop_reaction_selector
   import qs_pkg::*;
(
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Motion logic status, same clock.
   input wire logic motor_at_rest,
   // Drive controls.
   output logic servo_on,
   output logic ready_on,
   output logic dyn_brake,
   output logic decel_active,
   output logic [31:0] decel_rate,
   output logic [2:0] decel_src
);

   // Maps an option code to whether software may store it.
   function automatic logic option_legal(input logic [3:0] code);
      // Only the five supported reactions are listed; 3, 4 and 7 upward fall through.
      option_legal = (code == OPT_BRAKE) || (code == OPT_CTRL_OFF) || (code == OPT_QS_OFF) ||
                     (code == OPT_CTRL_HOLD) || (code == OPT_QS_HOLD);
   endfunction

   // True for the three torque-controlled modes.
   function automatic logic mode_is_torque(input logic [3:0] m);
      // These modes have no controlled stop here, so any reaction brakes.
      mode_is_torque = (m == MODE_CST) || (m == MODE_PROFILE_TORQUE) || (m == MODE_CONTINUOUS_TO_TORQUE);
   endfunction

   // Configuration and state registers.
   // Rates are stored as written; their unit belongs to the motion logic.
   logic [3:0] option_ff, nxt_option;          // Quick stop option code.
   logic [3:0] mode_ff, nxt_mode;              // Active control mode.
   logic [31:0] qs_decel_ff, nxt_qs_decel;     // Quick stop deceleration.
   logic [31:0] prof_decel_ff, nxt_prof_decel; // Profile deceleration.
   logic [31:0] home_acc_ff, nxt_home_acc;     // Homing acceleration.
   logic [31:0] table_decel_ff, nxt_table_decel; // Current point table entry's deceleration.
   drive_state_t state_ff, nxt_state;          // Drive state.
   logic hold_ff, nxt_hold;                    // Stay servo-on after the stop.
   logic brake_ff, nxt_brake;                  // Dynamic brake engaged.
   logic [2:0] src_ff, nxt_src;                // Selected rate source.
   logic [31:0] rate_ff, nxt_rate;             // Selected rate value.
   // The sticky refusal flag lets software see a dropped write afterwards.
   logic refused_ff, nxt_refused;              // Sticky: an illegal write was refused.
   logic pready_ff, nxt_pready;                // Bus answer.
   logic pslverr_ff, nxt_pslverr;              // Bus error answer.
   logic [31:0] prdata_ff, nxt_prdata;         // Read data.

   // Next values of the drive outputs, each registered straight onto its port.
   logic nxt_servo_on; // Servo power.
   logic nxt_ready_on; // Ready signal.
   logic nxt_dyn_brake; // Dynamic brake.
   logic nxt_decel_active; // Controlled stop under way.

   // Bus decode helpers.
   logic access;      // Access phase waiting for an answer.
   logic commit;      // Edge at which the master samples the answer.
   logic mapped;      // Address hits a register.
   logic bad_write;   // Write that must be refused.
   logic qs_req;      // Quick stop requested by the current write.
   logic en_req;      // Enable operation requested by the current write.
   logic [31:0] status_word; // Read-only status as packed for the bus.

   // The answer comes one cycle into the access phase, so every output stays a flop.
   always_comb begin
      // A transfer is answered after one access cycle: first access, then commit.
      access = psel && penable && !pready_ff;
      commit = psel && penable && pready_ff;
      // Aligned words up to the status word are mapped; the rest is unmapped.
      mapped = (paddr[1:0] == 2'b00) && (paddr <= OFS_STATUS);
      // Codes 3, 4 and anything unlisted are refused and leave the old code in place.
      bad_write = pwrite && (((paddr == OFS_OPTION) && !option_legal(pwdata[3:0])) ||
                             ((paddr == OFS_MODE) && (pwdata[3:0] > MODE_POINT_TABLE)));
      qs_req = commit && pwrite && !pslverr_ff && (paddr == OFS_COMMAND) && pwdata[CMD_QSTOP_BIT];
      en_req = commit && pwrite && !pslverr_ff && (paddr == OFS_COMMAND) && pwdata[CMD_ENABLE_BIT];
      // The state and drive flags are packed into one read-only word.
      status_word = 32'h0000_0000;
      status_word[ST_STATE_LSB +: 2] = state_ff;
      status_word[ST_SERVO_BIT] = servo_on;
      status_word[ST_READY_BIT] = ready_on;
      status_word[ST_BRAKE_BIT] = brake_ff;
      status_word[ST_DECEL_BIT] = decel_active;
      status_word[ST_SRC_LSB +: 3] = src_ff;
      status_word[ST_REFUSED_BIT] = refused_ff;
   end

   // Register file next values.
   always_comb begin
      // Every register holds unless a committed write moves it.
      nxt_option = option_ff;
      nxt_mode = mode_ff;
      nxt_qs_decel = qs_decel_ff;
      nxt_prof_decel = prof_decel_ff;
      nxt_home_acc = home_acc_ff;
      nxt_table_decel = table_decel_ff;
      nxt_refused = refused_ff;
      // The answer is a one-cycle pulse: raised after the first access edge, dropped after commit.
      nxt_pready = access;
      nxt_pslverr = 1'b0;
      nxt_prdata = prdata_ff;
      if (access) begin
         // Unmapped addresses and refused writes answer with an error.
         nxt_pslverr = !mapped || bad_write;
         // Read data is captured one edge early so that it stands together with pready.
         unique case (paddr)
            OFS_OPTION: nxt_prdata = {28'h0000000, option_ff};
            OFS_MODE: nxt_prdata = {28'h0000000, mode_ff};
            OFS_QS_DECEL: nxt_prdata = qs_decel_ff;
            OFS_PROF_DECEL: nxt_prdata = prof_decel_ff;
            OFS_HOME_ACC: nxt_prdata = home_acc_ff;
            OFS_TABLE_DECEL: nxt_prdata = table_decel_ff;
            OFS_STATUS: nxt_prdata = status_word;
            default: nxt_prdata = 32'h0000_0000;
         endcase
      end
      if (commit && pwrite && !pslverr_ff) begin
         // Writes take effect only at the sampling edge.
         // Command writes reach the state logic through qs_req and en_req instead.
         unique case (paddr)
            OFS_OPTION: nxt_option = pwdata[3:0];
            OFS_MODE: nxt_mode = pwdata[3:0];
            OFS_QS_DECEL: nxt_qs_decel = pwdata;
            OFS_PROF_DECEL: nxt_prof_decel = pwdata;
            OFS_HOME_ACC: nxt_home_acc = pwdata;
            OFS_TABLE_DECEL: nxt_table_decel = pwdata;
            // Writing one clears the refused flag.
            OFS_STATUS: nxt_refused = refused_ff && !pwdata[ST_REFUSED_BIT];
            default: nxt_refused = refused_ff;
         endcase
      end
      // A new refusal wins over a clear in the same cycle.
      if (commit && pslverr_ff && mapped) begin
         nxt_refused = 1'b1;
      end
   end

   // Drive state and reaction selection.
   always_comb begin
      // Hold every field unless a command or standstill moves the state.
      nxt_state = state_ff;
      nxt_hold = hold_ff;
      nxt_brake = brake_ff;
      nxt_src = src_ff;
      nxt_rate = rate_ff;
      unique case (state_ff)
         ST_SWITCH_ON_DISABLED: begin
            // Servo off; only an enable command brings the drive back.
            if (en_req) begin
               nxt_state = ST_OPERATION_ENABLED;
               // Enabling releases the dynamic brake.
               nxt_brake = 1'b0;
            end
         end
         ST_OPERATION_ENABLED: begin
            // A quick stop is only honoured while operation is enabled.
            if (qs_req) begin
               // Decide now whether the drive stays on once the motor stands.
               nxt_hold = (option_ff == OPT_CTRL_HOLD) || (option_ff == OPT_QS_HOLD);
               // Torque modes cannot hold a controlled stop, so they brake like code 0.
               if ((option_ff == OPT_BRAKE) || mode_is_torque(mode_ff)) begin
                  // Immediate disable, no controlled deceleration.
                  nxt_state = ST_SWITCH_ON_DISABLED;
                  nxt_brake = 1'b1;
                  nxt_src = SRC_NONE;
               end else begin
                  // Controlled stop: the option and then the mode pick the rate.
                  nxt_state = ST_DECELERATING;
                  if ((option_ff == OPT_QS_OFF) || (option_ff == OPT_QS_HOLD)) begin
                     // Fixed quick stop rate regardless of mode.
                     nxt_src = SRC_QUICK_STOP;
                     nxt_rate = qs_decel_ff;
                  end else if ((mode_ff == MODE_CSP) || (mode_ff == MODE_CSV)) begin
                     nxt_src = SRC_QUICK_STOP;
                     nxt_rate = qs_decel_ff;
                  end else if (mode_ff == MODE_HOMING) begin
                     nxt_src = SRC_HOMING;
                     nxt_rate = home_acc_ff;
                  end else if (mode_ff == MODE_POINT_TABLE) begin
                     nxt_src = SRC_POINT_TABLE;
                     nxt_rate = table_decel_ff;
                  end else begin
                     // Profile position, profile velocity and jog.
                     nxt_src = SRC_PROFILE;
                     nxt_rate = prof_decel_ff;
                  end
               end
            end
         end
         ST_DECELERATING: begin
            // Ending: hold servo on for codes 5 and 6, else disable.
            // No stop timeout is kept here: the motion logic must report standstill.
            // Rate and source stay latched after the stop, so software can read what was used.
            if (motor_at_rest) begin
               nxt_state = hold_ff ? ST_QUICK_STOP_ACTIVE : ST_SWITCH_ON_DISABLED;
            end
         end
         ST_QUICK_STOP_ACTIVE: begin
            // Servo stays on until the controller re-enables operation.
            // The brake is never set on this path, so nothing needs releasing.
            if (en_req) begin
               nxt_state = ST_OPERATION_ENABLED;
            end
         end
      endcase
   end

   // Drive outputs follow the next state, so they change on the same edge as the state.
   // Deriving them here keeps the output flops free of logic of their own.
   always_comb begin
      // Ready and servo share one level: only switch-on-disabled turns them off.
      nxt_servo_on = (nxt_state != ST_SWITCH_ON_DISABLED);
      nxt_ready_on = (nxt_state != ST_SWITCH_ON_DISABLED);
      // The brake only ever engages together with the disable.
      nxt_dyn_brake = nxt_brake;
      // Deceleration is shown for exactly as long as the state lasts.
      nxt_decel_active = (nxt_state == ST_DECELERATING);
   end

   // Register file and bus answer; the asynchronous reset loads constants only.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         // Reset leaves the option at quick-stop-then-off and every rate at zero.
         option_ff <= OPTION_RST;
         mode_ff <= MODE_RST;
         qs_decel_ff <= RATE_RST;
         prof_decel_ff <= RATE_RST;
         home_acc_ff <= RATE_RST;
         table_decel_ff <= RATE_RST;
         refused_ff <= 1'b0;
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff <= 32'h0000_0000;
      end else begin
         option_ff <= nxt_option;
         mode_ff <= nxt_mode;
         qs_decel_ff <= nxt_qs_decel;
         prof_decel_ff <= nxt_prof_decel;
         home_acc_ff <= nxt_home_acc;
         table_decel_ff <= nxt_table_decel;
         refused_ff <= nxt_refused;
         pready_ff <= nxt_pready;
         pslverr_ff <= nxt_pslverr;
         prdata_ff <= nxt_prdata;
      end
   end

   // Drive state and outputs; reset leaves the drive disabled with the brake released.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_ff <= ST_SWITCH_ON_DISABLED;
         hold_ff <= 1'b0;
         brake_ff <= 1'b0;
         src_ff <= SRC_NONE;
         rate_ff <= RATE_RST;
         servo_on <= 1'b0;
         ready_on <= 1'b0;
         dyn_brake <= 1'b0;
         decel_active <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         hold_ff <= nxt_hold;
         brake_ff <= nxt_brake;
         src_ff <= nxt_src;
         rate_ff <= nxt_rate;
         servo_on <= nxt_servo_on;
         ready_on <= nxt_ready_on;
         dyn_brake <= nxt_dyn_brake;
         decel_active <= nxt_decel_active;
      end
   end

   // Bus and rate outputs come straight from their flops.
   // The pready, pslverr and prdata flops load together at the access edge; pready and pslverr clear after commit.
   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
   assign decel_rate = rate_ff;
   assign decel_src = src_ff;

endmodule

/* File: test/qs_chk.sv */
// Checker for the quick stop reaction selector, watching the top module's ports.
// Assumes it is bound to every instance of the selector.
`timescale 1ns/10ps
module qs_chk (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // Bus answer, standstill report and drive outputs.
   input wire logic pready,
   input wire logic pslverr,
   input wire logic motor_at_rest,
   input wire logic servo_on,
   input wire logic ready_on,
   input wire logic dyn_brake,
   input wire logic decel_active,
   input wire logic [31:0] decel_rate,
   input wire logic [2:0] decel_src
);
   // One clock domain, so one clocking and one reset for all checks.
   default clocking @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   property p_ready_pair;
      ready_on == servo_on;
   endproperty
   a_ready_pair: assert property (p_ready_pair) else $error("ready and servo differ");
   property p_brake_off;
      dyn_brake |-> !servo_on;
   endproperty
   a_brake_off: assert property (p_brake_off) else $error("brake with servo on");
   property p_decel_on;
      decel_active |-> servo_on;
   endproperty
   a_decel_on: assert property (p_decel_on) else $error("servo off while decelerating");
   property p_decel_src;
      decel_active |-> decel_src inside {[3'h1:3'h4]};
   endproperty
   a_decel_src: assert property (p_decel_src) else $error("no rate source in deceleration");
   property p_rest_ends;
      decel_active && motor_at_rest |=> !decel_active;
   endproperty
   a_rest_ends: assert property (p_rest_ends) else $error("deceleration outlived standstill");
   property p_rate_held;
      decel_active && $past(decel_active) |-> $stable(decel_rate);
   endproperty
   a_rate_held: assert property (p_rate_held) else $error("rate changed in deceleration");
   property p_no_brake_decel;
      $rose(decel_active) |-> !dyn_brake;
   endproperty
   a_no_brake_decel: assert property (p_no_brake_decel) else $error("brake in deceleration");
   property p_err_pulse;
      pslverr |-> pready ##1 !pready;
   endproperty
   a_err_pulse: assert property (p_err_pulse) else $error("error outside a single answer");
endmodule
bind quick_stop_reaction_selector qs_chk i_chk (.pclk(pclk), .presetn(presetn), .pready(pready),
   .pslverr(pslverr), .motor_at_rest(motor_at_rest), .servo_on(servo_on), .ready_on(ready_on),
   .dyn_brake(dyn_brake), .decel_active(decel_active), .decel_rate(decel_rate), .decel_src(decel_src));

/* File: test/qs_motion_model.sv */
// Motion model behind the selector: reports standstill some cycles after a deceleration starts.
// Assumes the bench sets stop_delay between runs, from 1 for a prompt stop up to 8 for a slow one.
`timescale 1ns/10ps
module qs_motion_model (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // Drive command and stop length.
   input wire logic decel_active,
   input wire logic [3:0] stop_delay,
   // Standstill report.
   output logic motor_at_rest
);
   logic [3:0] cnt_ff; // Cycles spent decelerating so far.
   // Standstill is reported only while decelerating and for the one cycle after decel_active falls, as it is registered.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_ff <= 4'h0;
         motor_at_rest <= 1'b0;
      end else begin
         cnt_ff <= decel_active ? cnt_ff + 4'h1 : 4'h0;
         motor_at_rest <= decel_active && (cnt_ff >= stop_delay);
      end
   end
endmodule

/* File: test/quick_stop_reaction_selector_test.sv */
// Testbench for the quick stop reaction selector: every option code against every mode.
// Assumes the motion model answers standstill and the checker is bound to the design.
`timescale 1ns/10ps
module quick_stop_reaction_selector_test;
   import qs_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [3:0] stop_delay = 4'h1;
   logic [31:0] prdata, decel_rate, rd;
   logic pready, pslverr, motor_at_rest, servo_on, ready_on, dyn_brake, decel_active, err;
   logic [2:0] decel_src;
   logic [31:0] rates [4]; // Rate written to each source register.
   logic [3:0] opts [5] = '{OPT_BRAKE, OPT_CTRL_OFF, OPT_QS_OFF, OPT_CTRL_HOLD, OPT_QS_HOLD};
   logic [3:0] bad [3] = '{4'h3, 4'h4, 4'h7}; // Codes the drive must turn away.
   int mismatches = 0;
   int n_compared = 0;
   // Free-running bus clock, 40 ns period.
   always #20 pclk = ~pclk;
   quick_stop_reaction_selector i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .motor_at_rest(motor_at_rest), .servo_on(servo_on), .ready_on(ready_on), .dyn_brake(dyn_brake),
      .decel_active(decel_active), .decel_rate(decel_rate), .decel_src(decel_src));
   qs_motion_model i_motion (.pclk(pclk), .presetn(presetn), .decel_active(decel_active),
      .stop_delay(stop_delay), .motor_at_rest(motor_at_rest));
   // Prints the counts and the verdict, then ends the run.
   task automatic stop_test();
      $display("Compared %0d values, %0d mismatches.", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // Compares one observed value with its expectation.
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // One bus transfer; the request is held until pready is sampled high.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 16) begin
         mismatches++;
         stop_test();
      end
   endtask
   // Rate source expected for an option and a mode; none means a brake stop.
   function automatic logic [2:0] exp_src(input logic [3:0] o, input logic [3:0] m);
      if (o == OPT_BRAKE) return SRC_NONE;
      if (m inside {MODE_CST, MODE_PROFILE_TORQUE, MODE_CONTINUOUS_TO_TORQUE}) return SRC_NONE;
      if (o == OPT_QS_OFF || o == OPT_QS_HOLD || m inside {MODE_CSP, MODE_CSV}) return SRC_QUICK_STOP;
      if (m == MODE_HOMING) return SRC_HOMING;
      if (m == MODE_POINT_TABLE) return SRC_POINT_TABLE;
      return SRC_PROFILE;
   endfunction
   // Main sequence: reset values, refusals, then the full reaction table.
   initial begin
      int k;
      logic [2:0] src;
      logic hold;
      void'($urandom(32'h7f18dfbc));
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, OFS_OPTION, 32'h0);
      chk("option reset", rd, {28'h0, OPTION_RST});
      foreach (bad[i]) begin
         apb(1'b1, OFS_OPTION, {28'h0, bad[i]});
         chk("refused error", err, 32'h1);
         apb(1'b0, OFS_OPTION, 32'h0);
         chk("option kept", rd, {28'h0, OPTION_RST});
      end
      apb(1'b1, OFS_MODE, 32'h0000_000a);
      chk("mode refused", err, 32'h1);
      apb(1'b0, OFS_MODE, 32'h0);
      chk("mode kept", rd, {28'h0, MODE_RST});
      apb(1'b0, OFS_STATUS, 32'h0);
      chk("refused flag", rd[ST_REFUSED_BIT], 32'h1);
      apb(1'b1, OFS_STATUS, 32'h1 << ST_REFUSED_BIT);
      apb(1'b0, OFS_STATUS, 32'h0);
      chk("refused cleared", rd[ST_REFUSED_BIT], 32'h0);
      apb(1'b0, 8'h20, 32'h0);
      chk("unmapped error", err, 32'h1);
      $display("Test refusals done.");
      for (int i = 0; i < 5; i++) begin
         for (int m = 0; m < 10; m++) begin
            src = exp_src(opts[i], 4'(m));
            hold = opts[i] == OPT_CTRL_HOLD || opts[i] == OPT_QS_HOLD;
            stop_delay <= 4'($urandom_range(8, 1));
            apb(1'b1, OFS_OPTION, {28'h0, opts[i]});
            apb(1'b1, OFS_MODE, 32'(m));
            for (k = 0; k < 4; k++) begin
               rates[k] = $urandom;
               apb(1'b1, OFS_QS_DECEL + 8'(4 * k), rates[k]);
            end
            apb(1'b1, OFS_COMMAND, 32'h2);
            apb(1'b1, OFS_COMMAND, 32'h1);
            @(negedge pclk);
            chk("brake", dyn_brake, 32'(src == SRC_NONE));
            chk("decelerating", decel_active, 32'(src != SRC_NONE));
            chk("servo during stop", servo_on, 32'(src != SRC_NONE));
            chk("ready during stop", ready_on, 32'(src != SRC_NONE));
            if (src != SRC_NONE) begin
               chk("source", decel_src, 32'(src));
               chk("rate", decel_rate, rates[src - 3'h1]);
               k = 0;
               while (decel_active !== 1'b0 && k < 50) begin
                  @(negedge pclk);
                  k++;
               end
               if (k >= 50) begin
                  mismatches++;
                  stop_test();
               end
               chk("servo after stop", servo_on, 32'(hold));
            end
            apb(1'b0, OFS_STATUS, 32'h0);
            chk("end state", rd[1:0], (src != SRC_NONE && hold) ? 32'h3 : 32'h0);
            $display("Test option %0h mode %0d done.", opts[i], m);
         end
      end
      stop_test();
   end
endmodule
